// ===== bench/cso_status_asserts.sv
// Concurrent checks on the ports of the status outputs block.
`timescale 1ns/1ps
module cso_status_asserts
   import cso_pkg::*;
#(
   parameter int PINS = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic [31:0] wb_dat_out,
   input wire logic tx_request_in,
   input wire logic tx_start_out,
   input wire logic [15:0] bit_div_out,
   input wire logic [PINS-1:0] pin_oe_out
);
   default clocking dclk @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Cycles that a pending character has waited for its start bit.
   logic [15:0] lead_cnt;
   // The count clears whenever no character is waiting.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lead_cnt <= 16'h0000;
      end else if (tx_request_in && !tx_start_out) begin
         lead_cnt <= lead_cnt + 16'h0001;
      end else begin
         lead_cnt <= 16'h0000;
      end
   end
   // A bus request that has not yet been answered.
   sequence bus_req_s;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   ack_reply_a: assert property (bus_req_s |=> wb_ack_out)
      else $error("bus request not answered in one cycle");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("acknowledge longer than one cycle");
   ack_cause_a: assert property (wb_ack_out |-> $past(wb_stb_in))
      else $error("acknowledge without a request");
   dat_hold_a: assert property ($fell(wb_ack_out) |-> $stable(wb_dat_out))
      else $error("read data changed after acknowledge");
   div_floor_a: assert property (bit_div_out >= 16'(CSO_MIN_DIV))
      else $error("bit period shorter than the rate limit");
   start_lead_a: assert property (tx_start_out |-> lead_cnt == bit_div_out)
      else $error("start bit not one bit period after request");
   start_pulse_a: assert property (tx_start_out |=> !tx_start_out)
      else $error("start pulse longer than one cycle");
   rst_vals_a: assert property ($fell(rst_in) |-> bit_div_out == CSO_DIV_RESET
      && pin_oe_out == '0)
      else $error("wrong values after reset");
endmodule : cso_status_asserts

bind cso_status_outputs cso_status_asserts #(.PINS(PINS)) u_cso_status_asserts (
   .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
   .tx_request_in(tx_request_in), .tx_start_out(tx_start_out),
   .bit_div_out(bit_div_out), .pin_oe_out(pin_oe_out));

// ===== bench/cso_status_outputs_tb_top.sv
// Testbench of the status outputs block with a UART model beside it.
`timescale 1ns/1ps
module cso_status_outputs_tb_top;
   import cso_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cyc = 1'b0, we = 1'b0, ack, susp = 1'b0, chg = 1'b0;
   logic rxa = 1'b0, send = 1'b0, req, start, stop, done, pd;
   logic [3:0] adr = 4'h0, pin, oe;
   logic [31:0] wdat = 32'h0, rdat;
   logic [15:0] div, rnd;
   logic [31:0] expq[$];
   int err_total = 0, check_count = 0;
   integer seed = 32'h8dcfb461;
   cso_status_outputs #(.PINS(4), .LAMP_CYC(20)) u_cso_status_outputs (
      .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .suspend_in(susp),
      .charger_port_in(chg), .tx_request_in(req), .tx_start_out(start),
      .tx_stop_in(stop), .tx_done_in(done), .rx_active_in(rxa),
      .pin_out(pin), .pin_oe_out(oe), .serial_pulldown_oe_out(pd),
      .bit_div_out(div));
   cso_uart_model u_cso_uart_model (.clk_in(clk_in), .rst_in(rst_in),
      .send_in(send), .tx_start_in(start), .bit_div_in(div),
      .tx_request_out(req), .tx_stop_out(stop), .tx_done_out(done));
   // The clock toggles every half period of 10 ns.
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   // Compares one value and counts it.
   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // One classic bus cycle, held until acknowledged.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      cyc <= 1'b0;
      @(posedge clk_in);
   endtask : bus
   // A read whose expected data waits in the queue.
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   // Reports the counts and the verdict, then stops.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   // Read data is compared when its acknowledge appears.
   always @(posedge clk_in) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
         check("read data", rdat, expq.pop_front());
      end
   end
   // A hang is cut short well past the expected run length.
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      finish_test();
   end
   // Main sequence: registers, transmit, lamps, suspend.
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(CSO_ADDR_CTRL, CSO_CTRL_RESET);
      rd(CSO_ADDR_BAUD, 32'h0000_01B2);
      bus(1'b1, 4'hC, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0);
      bus(1'b1, CSO_ADDR_BAUD, 32'h0000_0005);
      rd(CSO_ADDR_BAUD, 32'h0000_0011);
      rnd = 16'h0011 + {12'h000, 4'($random(seed))};
      bus(1'b1, CSO_ADDR_BAUD, {16'h0000, rnd});
      rd(CSO_ADDR_BAUD, {16'h0000, rnd});
      check("divisor port", 32'(div), {16'h0000, rnd});
      bus(1'b1, CSO_ADDR_CTRL, 32'h0000_0D63);
      send <= 1'b1;
      @(posedge clk_in);
      send <= 1'b0;
      @(posedge clk_in iff start === 1'b1);
      check("driver enable", 32'(pin[0]), 32'h1);
      check("lamps lit", 32'(oe[3:1]), 32'h5);
      @(posedge clk_in iff stop === 1'b1);
      check("driver enable at stop", 32'(pin[0]), 32'h0);
      @(posedge clk_in iff done === 1'b1);
      rxa <= 1'b1;
      @(posedge clk_in);
      rxa <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("receive lamps", 32'(oe[3:1]), 32'h6);
      check("lamp level", 32'(pin[2]), 32'h0);
      repeat (10) @(posedge clk_in);
      rxa <= 1'b1;
      @(posedge clk_in);
      rxa <= 1'b0;
      repeat (15) @(posedge clk_in);
      check("lamp retrigger", 32'(oe[2]), 32'h1);
      repeat (10) @(posedge clk_in);
      check("lamps dark", 32'(oe[3:1]), 32'h0);
      bus(1'b1, CSO_ADDR_CTRL, 32'h0000_11D1);
      susp <= 1'b1;
      repeat (5) @(posedge clk_in);
      check("suspend pins", 32'(pin[2:0]), 32'h1);
      check("pull-down", 32'(pd), 32'h1);
      chg <= 1'b1;
      repeat (5) @(posedge clk_in);
      check("charger", 32'(pin[2]), 32'h1);
      rd(CSO_ADDR_STATUS, 32'h0000_0003);
      bus(1'b1, CSO_ADDR_CTRL, 32'h0000_31D1);
      check("charger low", 32'(pin[2]), 32'h0);
      susp <= 1'b0;
      repeat (5) @(posedge clk_in);
      check("active pins", 32'(pin[2:0]), 32'h6);
      check("no pull-down", 32'(pd), 32'h0);
      finish_test();
   end
endmodule : cso_status_outputs_tb_top

// ===== bench/cso_uart_model.sv
// Model of the UART transmitter that the block sequences.
`timescale 1ns/1ps
module cso_uart_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic send_in,
   input wire logic tx_start_in,
   input wire logic [15:0] bit_div_in,
   output logic tx_request_out,
   output logic tx_stop_out,
   output logic tx_done_out
);
   // Cycles left in the frame; the last bit period is the stop bit.
   int left;
   // Asks for a character, holds it until started, then plays a frame.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_request_out <= 1'b0;
         tx_stop_out <= 1'b0;
         tx_done_out <= 1'b0;
         left <= 0;
      end else if (tx_request_out && tx_start_in) begin
         tx_request_out <= 1'b0;
         left <= 10 * int'(bit_div_in);
      end else if (left != 0) begin
         left <= left - 1;
         tx_stop_out <= left > 1 && left <= int'(bit_div_in) + 1;
         tx_done_out <= left == 1;
      end else if (send_in) begin
         tx_request_out <= 1'b1;
         tx_done_out <= 1'b0;
      end else begin
         tx_done_out <= 1'b0;
      end
   end
endmodule : cso_uart_model

// ===== design/cso_pkg.sv
// Package of constants and types for the status outputs block.
package cso_pkg;
   // Wishbone register byte addresses.
   localparam logic [3:0] CSO_ADDR_CTRL = 4'h0;
   localparam logic [3:0] CSO_ADDR_STATUS = 4'h4;
   localparam logic [3:0] CSO_ADDR_BAUD = 4'h8;
   // Control register field positions.
   localparam int CSO_CTRL_PIN_LSB = 0;
   localparam int CSO_CTRL_PD_BIT = 12;
   localparam int CSO_CTRL_DCP_POL_BIT = 13;
   // Control register reset value: all pins off, pull-down off.
   localparam logic [31:0] CSO_CTRL_RESET = 32'h0000_0000;
   // Clock rate and the fastest allowed serial rate.
   localparam int CSO_CLK_HZ = 50_000_000;
   localparam int CSO_MAX_BAUD = 3_000_000;
   // Least bit period in clock cycles, rounded up (17 at 50 MHz).
   localparam int CSO_MIN_DIV = (CSO_CLK_HZ + CSO_MAX_BAUD - 1) / CSO_MAX_BAUD;
   // Reset value of the baud divisor: 115200 baud is about 434 cycles.
   localparam logic [15:0] CSO_DIV_RESET = 16'h01B2;
   // Lamp stretch time in microseconds and its count of cycles.
   localparam int CSO_LAMP_US = 50_000;
   localparam int CSO_LAMP_CYC = CSO_LAMP_US * (CSO_CLK_HZ / 1_000_000);

   // Function that a configurable pin carries.
   typedef enum logic [2:0] {
      CSO_FN_OFF = 3'h0,
      CSO_FN_POWER_N = 3'h1,
      CSO_FN_SLEEP_N = 3'h2,
      CSO_FN_DRIVER_EN = 3'h3,
      CSO_FN_TX_LAMP = 3'h4,
      CSO_FN_RX_LAMP = 3'h5,
      CSO_FN_TRAFFIC = 3'h6,
      CSO_FN_CHARGER = 3'h7
   } cso_fn_t;

   // Line-driver sequencer states, one-hot.
   typedef enum logic [3:0] {
      CSO_ST_IDLE = 4'b0001,
      CSO_ST_LEAD = 4'b0010,
      CSO_ST_FRAME = 4'b0100,
      CSO_ST_STOP = 4'b1000
   } cso_state_t;

   // Drive of one three-state pin.
   typedef struct packed {
      logic out;
      logic oe;
   } cso_pin_t;
endpackage : cso_pkg

// ===== design/cso_status_outputs.sv
// Status outputs for configurable pins with a Wishbone register port.
`timescale 1ns/1ps
module cso_status_outputs
   import cso_pkg::*;
#(
   parameter int PINS = 4,
   parameter int LAMP_CYC = CSO_LAMP_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic suspend_in,
   input wire logic charger_port_in,
   input wire logic tx_request_in,
   output logic tx_start_out,
   input wire logic tx_stop_in,
   input wire logic tx_done_in,
   input wire logic rx_active_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe_out,
   output logic serial_pulldown_oe_out,
   output logic [15:0] bit_div_out
);

   // Control register and baud divisor.
   logic [31:0] ctrl;
   logic [15:0] bit_div;
   // Synchronisers for the pin-side inputs.
   logic [1:0] susp_sync;
   logic [1:0] dcp_sync;
   // Charger detection latch.
   logic dcp_seen;
   // Sequencer state and bit timer.
   cso_state_t state;
   cso_state_t next_state;
   logic [15:0] bit_cnt;
   logic bit_tick;
   logic line_driver_enable;
   // One-shot timers for transmit and receive activity.
   logic [31:0] tx_shot;
   logic [31:0] rx_shot;
   logic tx_lit;
   logic rx_lit;
   // Bus decode wires.
   logic bus_req;
   logic hit_ctrl;
   logic hit_status;
   logic hit_baud;
   logic [31:0] wr_mask;
   logic [15:0] div_wr;
   logic suspended;

   // Overview of the block for the next engineer.
   // The block owns no serial datapath of its own.
   // It watches a transmitter and a receiver that share its clock.
   // It turns their activity into drives for a handful of pins.
   // Each pin carries one function, chosen by a three-bit field.
   // The fields sit side by side at the bottom of the control word.
   // Field zero switches a pin off, and the pin then floats.
   // A floating pin relies on the board to give it a level.
   //
   // Register map in words of the bus.
   // The control word holds the pin fields and two option bits.
   // One option bit pulls the serial lines low during suspend.
   // The other option bit turns the charger output active low.
   // The status word is read only and reflects live state.
   // Its low bits are suspend, charger seen and driver enable.
   // Above them sit the two lamp timers and the sequencer busy bit.
   // The divisor word gives the bit period in clock cycles.
   // Writes to unmapped words are dropped without a bus error.
   // Reads of unmapped words return zero for the same reason.
   //
   // Bus timing.
   // A request is taken on the first edge that sees it.
   // The acknowledge follows one cycle later and lasts one cycle.
   // While the acknowledge stands, the same request is not taken again.
   // Read data stays in its register until the next read.
   //
   // Line-driver sequencer.
   // A waiting character moves the sequencer out of idle.
   // The enable then leads the start bit by one full bit period.
   // The start pulse to the transmitter marks the end of that lead.
   // The enable falls at once when the stop bit begins.
   // That fall is combinational so that no cycle of overlap remains.
   // The sequencer then waits for the transmitter to finish.
   // Only after that may the next character ask for the line.
   // A divisor change while a character runs takes effect next bit.
   //
   // Activity lamps.
   // Each lamp timer is loaded while its activity is present.
   // The timer then counts down and keeps the lamp lit meanwhile.
   // Fresh activity reloads the timer, so lamps retrigger.
   // A lamp pin never drives high; it only sinks current or floats.
   // The stretch time is a parameter so that tests can shorten it.
   //
   // Suspend and charger.
   // Suspend and the charger detect come from outside the clock.
   // Each passes two flip-flops before any logic reads it.
   // The charger latch sets only while the block is suspended.
   // Leaving suspend clears the latch, as a host must be present.
   // The polarity option is applied at the pin, not in the latch.
   // The status word therefore always shows the latch as active high.
   //
   // Limits a user must know.
   // At most four pins fit in the control word as laid out.
   // The divisor floor assumes the clock rate of the package.
   // A different clock needs the floor constant to be recomputed.
   // The lamp timers are wide enough for stretch times of seconds.
   // No pin output depends on the bus acknowledge or read path.
   // So a stalled bus cannot freeze the status outputs.

   // Byte-enable mask expanded from the select lines.
   function automatic logic [31:0] sel_mask(input logic [3:0] sel);
      sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : sel_mask

   // Field of the pin function for one pin.
   function automatic cso_fn_t pin_fn(input logic [31:0] c, input int i);
      pin_fn = cso_fn_t'(c[CSO_CTRL_PIN_LSB + 3*i +: 3]);
   endfunction : pin_fn

   // Request decode; a new request is taken when no ack is pending.
   assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign hit_ctrl = wb_adr_in == CSO_ADDR_CTRL;
   assign hit_status = wb_adr_in == CSO_ADDR_STATUS;
   assign hit_baud = wb_adr_in == CSO_ADDR_BAUD;
   assign wr_mask = sel_mask(wb_sel_in);
   // Divisor merged lane by lane with the write data.
   assign div_wr = (bit_div & ~wr_mask[15:0]) |
      (wb_dat_in[15:0] & wr_mask[15:0]);
   assign suspended = susp_sync[1];
   assign bit_div_out = bit_div;

   // Bus slave: one-cycle ack; unmapped reads return zero, writes ignored.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= bus_req;
         if (bus_req && !wb_we_in) begin
            if (hit_ctrl) begin
               wb_dat_out <= ctrl;
            end else if (hit_status) begin
               wb_dat_out <= {26'h0, state == CSO_ST_IDLE ? 1'b0 : 1'b1,
                  rx_lit, tx_lit, line_driver_enable, dcp_seen, suspended};
            end else if (hit_baud) begin
               wb_dat_out <= {16'h0000, bit_div};
            end else begin
               wb_dat_out <= 32'h0000_0000;
            end
         end
      end
   end

   // Register writes; the divisor never goes below the 3 Mbaud bit time.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl <= CSO_CTRL_RESET;
         bit_div <= CSO_DIV_RESET;
      end else if (bus_req && wb_we_in) begin
         if (hit_ctrl) begin
            ctrl <= (ctrl & ~wr_mask) | (wb_dat_in & wr_mask);
         end
         if (hit_baud) begin
            // A too short period is raised to the floor, not refused.
            bit_div <= (div_wr < 16'(CSO_MIN_DIV)) ?
               16'(CSO_MIN_DIV) : div_wr;
         end
      end
   end

   // Two-flop synchronisers for suspend and charger detection.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         susp_sync <= 2'b00;
         dcp_sync <= 2'b00;
      end else begin
         susp_sync <= {susp_sync[0], suspend_in};
         dcp_sync <= {dcp_sync[0], charger_port_in};
      end
   end

   // Charger latch: set only when seen in suspend, cleared when active.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dcp_seen <= 1'b0;
      end else if (!suspended) begin
         dcp_seen <= 1'b0;
      end else if (dcp_sync[1]) begin
         dcp_seen <= 1'b1;
      end
   end

   // Bit timer restarts on leaving idle, ticks once per bit period.
   assign bit_tick = bit_cnt == 16'h0000;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt <= 16'h0000;
      end else if (state == CSO_ST_IDLE || bit_tick) begin
         bit_cnt <= bit_div - 16'h0001;
      end else begin
         bit_cnt <= bit_cnt - 16'h0001;
      end
   end

   // Sequencer next state: lead bit, frame, then stop bit.
   always_comb begin
      next_state = state;
      case (state)
         CSO_ST_IDLE: begin
            if (tx_request_in) begin
               next_state = CSO_ST_LEAD;
            end
         end
         CSO_ST_LEAD: begin
            // Exactly one bit period of lead time.
            if (bit_tick) begin
               next_state = CSO_ST_FRAME;
            end
         end
         CSO_ST_FRAME: begin
            // Enable drops the moment the stop bit begins.
            if (tx_stop_in) begin
               next_state = CSO_ST_STOP;
            end
         end
         CSO_ST_STOP: begin
            if (tx_done_in) begin
               next_state = CSO_ST_IDLE;
            end
         end
         default: begin
            next_state = CSO_ST_IDLE;
         end
      endcase
   end

   // Sequencer state register.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= CSO_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Enable high during lead and frame; start pulse at end of lead.
   assign line_driver_enable = (state == CSO_ST_LEAD) ||
      (state == CSO_ST_FRAME && !tx_stop_in);
   assign tx_start_out = (state == CSO_ST_LEAD) && bit_tick;

   // One-shots: reload on activity, count down to keep the lamp lit.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_shot <= 32'h0000_0000;
         rx_shot <= 32'h0000_0000;
      end else begin
         if (line_driver_enable) begin
            tx_shot <= 32'(LAMP_CYC);
         end else if (tx_shot != 32'h0000_0000) begin
            tx_shot <= tx_shot - 32'h0000_0001;
         end
         if (rx_active_in) begin
            rx_shot <= 32'(LAMP_CYC);
         end else if (rx_shot != 32'h0000_0000) begin
            rx_shot <= rx_shot - 32'h0000_0001;
         end
      end
   end
   assign tx_lit = tx_shot != 32'h0000_0000;
   assign rx_lit = rx_shot != 32'h0000_0000;

   // Pull-down on suspend only when enabled.
   assign serial_pulldown_oe_out = suspended && ctrl[CSO_CTRL_PD_BIT];

   // Per-pin function multiplexer.
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         cso_pin_t drv;
         always_comb begin
            drv.out = 1'b0;
            drv.oe = 1'b0;
            case (pin_fn(ctrl, gi))
               CSO_FN_POWER_N: begin
                  drv.out = suspended;
                  drv.oe = 1'b1;
               end
               CSO_FN_SLEEP_N: begin
                  drv.out = !suspended;
                  drv.oe = 1'b1;
               end
               CSO_FN_DRIVER_EN: begin
                  drv.out = line_driver_enable;
                  drv.oe = 1'b1;
               end
               CSO_FN_TX_LAMP: begin
                  drv.oe = tx_lit;
               end
               CSO_FN_RX_LAMP: begin
                  drv.oe = rx_lit;
               end
               CSO_FN_TRAFFIC: begin
                  drv.oe = tx_lit || rx_lit;
               end
               CSO_FN_CHARGER: begin
                  drv.out = dcp_seen ^ ctrl[CSO_CTRL_DCP_POL_BIT];
                  drv.oe = 1'b1;
               end
               default: begin
                  drv.out = 1'b0;
                  drv.oe = 1'b0;
               end
            endcase
         end
         assign pin_out[gi] = drv.out;
         assign pin_oe_out[gi] = drv.oe;
      end
   endgenerate

endmodule : cso_status_outputs
